// ### verilog/hsp_defines.svh
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: included by bare name from the design files
// Notes:   command codes double as register addresses on the bus
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH

// Command codes
`define CMD_OUTPUT_CTRL     8'h03
`define CMD_OT_FAULT        8'h4f
`define CMD_OT_WARN         8'h51
`define CMD_VENDOR_STATUS   8'h80
`define CMD_TEMPERATURE     8'h8d
`define CMD_ALERT_SUPPRESS  8'hd8
`define CMD_FAULT_SUMMARY   8'he1

// Output control values
`define OUT_ON_VALUE        8'h80
`define OUT_OFF_VALUE       8'h00
`define OUT_CTRL_ENABLE_BIT 7

// Reset values
`define OUT_CTRL_RESET      8'h80
`define OT_WARN_RESET       16'h007d
`define OT_FAULT_RESET      16'h0096
`define ALERT_SUPPRESS_RESET 16'h0000

// Bit positions shared by suppress and summary; vendor status has its own short bit
`define BIT_OV              0
`define BIT_UV              1
`define BIT_LATCHED         2
`define BIT_OT_WARN         3
`define BIT_OT_FAULT        4
`define BIT_SHORT           5
`define VS_BIT_SHORT        0

// Timing figures
`define CLK_PERIOD_NS       40
`define SAMPLE_PERIOD_NS    1000000
`define DIODE_PULSE_NS      100000

`endif

// ### verilog/hsp_pkg.sv
// Purpose: shared types of the hot swap protection logic
// Assumes: constants live in hsp_defines.svh
// Notes:   state structs hold every flop of their module but the reset sync and the data enable
package hsp_pkg;

  typedef enum logic [1:0] {BRK_48MV, BRK_96MV, BRK_193MV} breaker_level_t;

  // Pin levels from outside the clock domain
  typedef struct packed {
    logic uv_ok;
    logic ov_high;
    logic sense_over;
    logic vref_ok;
    logic supply_ok;
    logic scl;
    logic sda;
  } pin_vec_t;

  // Byte written by the host, with its place in the frame
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] idx;
  } link_ev_t;

  typedef struct packed {
    logic [3:0]  cnt;
    logic [1:0]  idx;
    logic [7:0]  sh;
    logic        match;
    logic        rw;
    logic        nack;
    logic [15:0] rd;
    link_ev_t    ev;
    logic        tgl;
  } link_state_t;

  typedef struct packed {
    pin_vec_t       s1;
    pin_vec_t       s2;
    pin_vec_t       s3;
    pin_vec_t       flt;
    logic [2:0]     ev_sync;
    logic           link_run;
    logic           restart;
    logic [7:0]     cmd;
    logic [7:0]     wr_lo;
    logic [7:0]     out_ctrl;
    logic [15:0]    ot_fault_thr;
    logic [15:0]    ot_warn_thr;
    logic [15:0]    suppress;
    logic [15:0]    temperature;
    logic           ot_warn;
    logic           ot_fault;
    logic           short_flag;
    logic           latched_off;
    logic [15:0]    ms_cnt;
    logic           pulse;
    logic           addr_done;
    logic [6:0]     bus_addr;
    breaker_level_t brk;
    logic           gate_on;
    logic           alert;
  } core_state_t;

endpackage

// ### verilog/smbus_link.sv
// Purpose: byte engine of the host link, clocked by the bus clock
// Assumes: held in reset outside frames; reset pulses at each start
// Notes:   word reads are LSB first; the read word is quasi-static
`timescale 1ns/10ps
module smbus_link
  import hsp_pkg::*;
(
  input  wire logic        link_clk_in,
  input  wire logic        link_rst_n_in,
  input  wire logic        sda_in,
  input  wire logic [6:0]  bus_addr_in,
  input  wire logic [15:0] rd_word_in,
  output logic             sda_oe_out,
  output link_ev_t         ev_out,
  output logic             ev_toggle_out
);

  link_state_t st;
  link_state_t next_st;
  logic [7:0]  byte_now;
  logic [7:0]  rd_byte;
  logic        next_oe;

  // Bit and byte sequencing on rising bus clock
  always_comb begin
    next_st  = st;
    byte_now = {st.sh[6:0], sda_in};
    if (st.cnt == 4'd8) begin
      next_st.cnt = 4'd0;
      if (st.idx != 2'd3) begin
        next_st.idx = st.idx + 2'd1;
      end
      if (st.rw && st.idx != 2'd0) begin
        next_st.nack = sda_in;
      end
    end else begin
      next_st.cnt = st.cnt + 4'd1;
      next_st.sh  = byte_now;
      if (st.cnt == 4'd7) begin
        if (st.idx == 2'd0) begin
          next_st.match = (byte_now[7:1] == bus_addr_in);
          next_st.rw    = byte_now[0];
          // Read word captured at the address byte and held for the rest of the frame
          next_st.rd    = rd_word_in;
        end else if (st.match && !st.rw) begin
          next_st.ev.data = byte_now;
          next_st.ev.idx  = st.idx;
          next_st.tgl     = ~st.tgl;
        end
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
    if (!link_rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Data and acknowledge driven while the bus clock is low
  always_comb begin
    rd_byte = (st.idx == 2'd1) ? st.rd[7:0] : st.rd[15:8];
    next_oe = 1'b0;
    if (st.cnt == 4'd8) begin
      next_oe = (st.idx == 2'd0) ? st.match : (st.match && !st.rw);
    end else if (st.match && st.rw && !st.nack &&
                 (st.idx == 2'd1 || st.idx == 2'd2)) begin
      next_oe = !rd_byte[3'd7 - st.cnt[2:0]];
    end
  end

  always_ff @(negedge link_clk_in or negedge link_rst_n_in) begin
    if (!link_rst_n_in) begin
      sda_oe_out <= 1'b0;
    end else begin
      sda_oe_out <= next_oe;
    end
  end

  assign ev_out        = st.ev;
  assign ev_toggle_out = st.tgl;

endmodule

// ### verilog/hot_swap_protect_control.sv
// Purpose: protection and control logic of a hot swap controller
// Assumes: analog comparators and converter deliver logic levels
// Notes:   host link runs on the bus clock inside smbus_link
`timescale 1ns/10ps
`include "hsp_defines.svh"
module hot_swap_protect_control
  import hsp_pkg::*;
#(
  parameter int         SAMPLE_CYCLES = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS,
  parameter logic [6:0] ADDR_BASE     = 7'h10 // Arbitrary base address
)
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        link_clk_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        undervolt_enable_pin_in,
  input  wire logic        overvolt_lockout_pin_in,
  input  wire logic        sense_over_4mv_in,
  input  wire logic        vref_above_2v55_in,
  input  wire logic        supply_above_4v1_in,
  input  wire logic [1:0]  addr_select_pin_0_in,
  input  wire logic [1:0]  addr_select_pin_1_in,
  input  wire logic [1:0]  addr_select_pin_2_in,
  input  wire logic        limit_select_setting_in,
  input  wire logic        breaker_scale_setting_in,
  input  wire logic [15:0] temp_code_in,
  input  wire logic        retry_exhausted_in,
  output logic             gate_on_out,
  output logic             diode_pulse_out,
  output logic             alert_out_pin_out,
  output logic             alert_out_pin_oe_out,
  output breaker_level_t   breaker_level_out,
  output logic [6:0]       bus_addr_out
);

  localparam int PULSE_CYCLES =
    (`DIODE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  localparam core_state_t CORE_INIT = '{
    out_ctrl:     `OUT_CTRL_RESET,
    ot_fault_thr: `OT_FAULT_RESET,
    ot_warn_thr:  `OT_WARN_RESET,
    suppress:     `ALERT_SUPPRESS_RESET,
    brk:          BRK_48MV,
    default:      '0
  };

  logic [1:0]  rst_sync;
  logic        rst_n;
  core_state_t st;
  core_state_t next_st;
  pin_vec_t    raw;
  pin_vec_t    diff;
  link_ev_t    ev;
  logic        ev_tgl;
  logic        ev_seen;
  logic        start;
  logic        stop;
  logic        sample_now;
  logic [15:0] rd_word;
  logic [15:0] wr_word;

  // Tri-level strap value: low 0, open 1, high 2
  function automatic logic [6:0] tri_val(input logic [1:0] p);
    tri_val = (p > 2'd2) ? 7'd2 : {5'd0, p};
  endfunction

  // Register read decode
  function automatic logic [15:0] reg_read(input logic [7:0]  c,
                                           input core_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    if (c == `CMD_OUTPUT_CTRL) begin
      w = {8'h00, s.out_ctrl};
    end else if (c == `CMD_OT_FAULT) begin
      w = s.ot_fault_thr;
    end else if (c == `CMD_OT_WARN) begin
      w = s.ot_warn_thr;
    end else if (c == `CMD_VENDOR_STATUS) begin
      w[`VS_BIT_SHORT] = s.short_flag;
    end else if (c == `CMD_TEMPERATURE) begin
      w = s.temperature;
    end else if (c == `CMD_ALERT_SUPPRESS) begin
      w = s.suppress;
    end else if (c == `CMD_FAULT_SUMMARY) begin
      w[`BIT_OV]       = s.flt.ov_high;
      w[`BIT_UV]       = !s.flt.uv_ok;
      w[`BIT_LATCHED]  = s.latched_off;
      w[`BIT_OT_WARN]  = s.ot_warn;
      w[`BIT_OT_FAULT] = s.ot_fault;
      w[`BIT_SHORT]    = s.short_flag;
    end
    reg_read = w;
  endfunction

  // Reset release through two flops
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Host link engine on the bus clock
  smbus_link u_link (
    .link_clk_in   (link_clk_in),
    .link_rst_n_in (st.link_run),
    .sda_in        (sda_in),
    .bus_addr_in   (st.bus_addr),
    .rd_word_in    (rd_word),
    .sda_oe_out    (sda_oe_out),
    .ev_out        (ev),
    .ev_toggle_out (ev_tgl)
  );

  // Pin sampling and derived events
  always_comb begin
    raw = '{uv_ok: undervolt_enable_pin_in, ov_high: overvolt_lockout_pin_in,
            sense_over: sense_over_4mv_in, vref_ok: vref_above_2v55_in,
            supply_ok: supply_above_4v1_in, scl: link_clk_in, sda: sda_in};
    diff       = pin_vec_t'(st.s2 ^ st.s3);
    rd_word    = reg_read(st.cmd, st);
    wr_word    = {ev.data, st.wr_lo};
    ev_seen    = st.ev_sync[2] ^ st.ev_sync[1];
    sample_now = (st.ms_cnt == 16'(PULSE_CYCLES - 1));
    start      = st.flt.scl && st.flt.sda && st.s3.scl && !st.s3.sda &&
                 !diff.sda && !diff.scl;
    stop       = st.flt.scl && !st.flt.sda && st.s3.scl && st.s3.sda &&
                 !diff.sda && !diff.scl;
  end

  // Next state of the core
  always_comb begin
    next_st         = st;
    next_st.s1      = raw;
    next_st.s2      = st.s1;
    next_st.s3      = st.s2;
    next_st.flt     = pin_vec_t'((~diff & st.s3) | (diff & st.flt));
    next_st.ev_sync = {st.ev_sync[1:0], ev_tgl};
    // Frame framing; a start pulses the link reset
    if (start) begin
      next_st.link_run = 1'b0;
      next_st.restart  = 1'b1;
    end else if (st.restart) begin
      next_st.link_run = 1'b1;
      next_st.restart  = 1'b0;
    end else if (stop) begin
      next_st.link_run = 1'b0;
    end
    // Millisecond sample timer and diode pulse
    if (st.ms_cnt == 16'(SAMPLE_CYCLES - 1)) begin
      next_st.ms_cnt = 16'h0000;
    end else begin
      next_st.ms_cnt = st.ms_cnt + 16'h0001;
    end
    next_st.pulse = (next_st.ms_cnt < 16'(PULSE_CYCLES));
    // Host writes; clears come before the sets below
    if (ev_seen) begin
      if (ev.idx == 2'd1) begin
        next_st.cmd = ev.data;
      end else if (ev.idx == 2'd2) begin
        next_st.wr_lo = ev.data;
        if (st.cmd == `CMD_OUTPUT_CTRL) begin
          next_st.out_ctrl = ev.data;
          if (ev.data == `OUT_OFF_VALUE) begin
            next_st.ot_fault   = 1'b0;
            next_st.short_flag = 1'b0;
          end
        end
      end else if (ev.idx == 2'd3) begin
        if (st.cmd == `CMD_OT_FAULT) begin
          next_st.ot_fault_thr = wr_word;
        end else if (st.cmd == `CMD_OT_WARN) begin
          next_st.ot_warn_thr = wr_word;
        end else if (st.cmd == `CMD_ALERT_SUPPRESS) begin
          next_st.suppress = wr_word;
        end
      end
    end
    // Sample taken and compared at the end of the pulse
    if (sample_now) begin
      next_st.temperature = temp_code_in;
      next_st.ot_warn = $signed(temp_code_in) > $signed(st.ot_warn_thr);
      if ($signed(temp_code_in) > $signed(st.ot_fault_thr)) begin
        next_st.ot_fault = 1'b1;
      end
    end
    if (st.flt.sense_over && !st.gate_on) begin
      next_st.short_flag = 1'b1;
    end
    if (!st.flt.uv_ok && next_st.flt.uv_ok) begin
      next_st.latched_off = 1'b0;
    end
    if (retry_exhausted_in) begin
      next_st.latched_off = 1'b1;
    end
    // Address and strap capture, once per reference release
    if (!st.addr_done && st.flt.supply_ok && st.flt.vref_ok) begin
      next_st.addr_done = 1'b1;
      next_st.bus_addr  = 7'(ADDR_BASE + tri_val(addr_select_pin_0_in) +
                             7'd3 * tri_val(addr_select_pin_1_in) +
                             7'd9 * tri_val(addr_select_pin_2_in));
      if (limit_select_setting_in) begin
        next_st.brk = breaker_scale_setting_in ? BRK_96MV : BRK_48MV;
      end else begin
        next_st.brk = breaker_scale_setting_in ? BRK_193MV : BRK_96MV;
      end
    end
    // Pins only gate the drive; registers stay as they are
    next_st.gate_on = st.out_ctrl[`OUT_CTRL_ENABLE_BIT] && st.flt.uv_ok &&
                      !st.flt.ov_high && !st.ot_fault &&
                      !st.latched_off && st.addr_done;
    next_st.alert = (st.ot_warn && !st.suppress[`BIT_OT_WARN]) ||
                    (st.ot_fault && !st.suppress[`BIT_OT_FAULT]) ||
                    (st.short_flag && !st.suppress[`BIT_SHORT]);
    // Reference low holds everything but the samplers in reset
    if (!st.flt.vref_ok) begin
      next_st         = CORE_INIT;
      next_st.s1      = raw;
      next_st.s2      = st.s1;
      next_st.s3      = st.s2;
      next_st.flt     = pin_vec_t'((~diff & st.s3) | (diff & st.flt));
      next_st.ev_sync = {st.ev_sync[1:0], ev_tgl};
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= CORE_INIT;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign gate_on_out          = st.gate_on;
  assign diode_pulse_out      = st.pulse;
  assign alert_out_pin_out    = 1'b0;
  assign alert_out_pin_oe_out = st.alert;
  assign sda_out              = 1'b0;
  assign breaker_level_out    = st.brk;
  assign bus_addr_out         = st.bus_addr;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  property p_uv_gate;
    !st.flt.uv_ok |=> !gate_on_out;
  endproperty
  a_uv_gate: assert property (p_uv_gate)
    else $error("gate on with enable pin low");

  property p_ov_gate;
    st.flt.ov_high |=> !gate_on_out;
  endproperty
  a_ov_gate: assert property (p_ov_gate)
    else $error("gate on with overvoltage");

  property p_ot_gate;
    st.ot_fault |=> !gate_on_out;
  endproperty
  a_ot_gate: assert property (p_ot_gate)
    else $error("gate on during temperature fault");

  property p_fault_cmp;
    sample_now && st.flt.vref_ok &&
    $signed(temp_code_in) > $signed(st.ot_fault_thr) |=>
      st.ot_fault ##1 !gate_on_out;
  endproperty
  a_fault_cmp: assert property (p_fault_cmp)
    else $error("fault limit not applied to sample");

  property p_warn_alert;
    st.ot_warn && !st.suppress[`BIT_OT_WARN] |=> alert_out_pin_oe_out;
  endproperty
  a_warn_alert: assert property (p_warn_alert)
    else $error("warning without alert");

  property p_short_alert;
    st.flt.sense_over && !st.gate_on && st.flt.vref_ok &&
    !st.suppress[`BIT_SHORT] |=> st.short_flag ##1
      (alert_out_pin_oe_out || $past(st.suppress[`BIT_SHORT]));
  endproperty
  a_short_alert: assert property (p_short_alert)
    else $error("shorted switch not flagged or alerted");

  property p_sample;
    $fell(diode_pulse_out) && st.flt.vref_ok |->
      st.temperature == $past(temp_code_in);
  endproperty
  a_sample: assert property (p_sample)
    else $error("sample not taken at pulse end");

  property p_read_temp;
    st.cmd == `CMD_TEMPERATURE |-> rd_word == st.temperature;
  endproperty
  a_read_temp: assert property (p_read_temp)
    else $error("temperature read mismatch");

  property p_latch_clear;
    !st.flt.uv_ok && next_st.flt.uv_ok && st.flt.vref_ok &&
    !retry_exhausted_in |=> !st.latched_off;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latched-off not cleared by enable toggle");

  property p_vref_clear;
    !st.flt.vref_ok |=> !st.addr_done && st.ot_warn_thr == `OT_WARN_RESET;
  endproperty
  a_vref_clear: assert property (p_vref_clear)
    else $error("logic not cleared while reference low");

  property p_addr_hold;
    st.addr_done && st.flt.vref_ok |=> $stable(bus_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("captured address changed");

  c_sample: cover property (sample_now && st.flt.vref_ok);
  c_op_write: cover property (ev_seen && ev.idx == 2'd2 &&
                              st.cmd == `CMD_OUTPUT_CTRL);
  c_short: cover property ($rose(st.short_flag));
  c_addr: cover property ($rose(st.addr_done));

endmodule

// ### sim/smbus_host.sv
// Purpose: bus host model driving clock and data of the register link
// Assumes: data line has a pull-up; clock idles high between frames
// Notes:   counts missing acknowledges for the bench to inspect
`timescale 1ns/10ps
module smbus_host (
  output logic      scl_out,
  output logic      pull_out,
  input  wire logic sda_in
);
  localparam int HALF = 40;
  localparam int HOLD = 240;
  int nack_cnt = 0;

  // Idle bus: clock high, data released
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end

  // One bit; data set in the low half, sampled at the rising edge
  task automatic clk_bit(input logic b, output logic r);
    pull_out = ~b;
    #(HALF);
    scl_out = 1'b1;
    r = sda_in;
    #(HALF);
    scl_out = 1'b0;
  endtask

  // Start or repeated start; long hold lets the pin sync see it
  task automatic start();
    #13;
    pull_out = 1'b0;
    #(HALF);
    scl_out = 1'b1;
    #(HOLD);
    pull_out = 1'b1;
    #(HOLD);
    scl_out = 1'b0;
  endtask

  // Stop leaves clock high and data released
  task automatic stop();
    pull_out = 1'b1;
    #(HALF);
    scl_out = 1'b1;
    #(HOLD);
    pull_out = 1'b0;
    #(HOLD);
  endtask

  // Byte out, high bit first, then the acknowledge slot
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    if (r !== 1'b0) nack_cnt++;
  endtask

  // Byte in; last byte answered with a release instead of an ack
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, r);
  endtask

  // Byte or word write, low byte first
  task automatic write(input logic [6:0] a, input logic [7:0] c,
                       input logic [15:0] d, input int n);
    start();
    put({a, 1'b0});
    put(c);
    put(d[7:0]);
    if (n == 2) put(d[15:8]);
    stop();
  endtask

  // Word read through a repeated start
  task automatic read(input logic [6:0] a, input logic [7:0] c,
                      output logic [15:0] d);
    start();
    put({a, 1'b0});
    put(c);
    start();
    put({a, 1'b1});
    get(1'b0, d[7:0]);
    get(1'b1, d[15:8]);
    stop();
  endtask
endmodule

// ### sim/hot_swap_protect_control_tb.sv
// Purpose: self-checking bench of the hot swap protection logic
// Assumes: host model drives the register link at 80 ns per bit
// Notes:   short sample period keeps the run brief
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module hot_swap_protect_control_tb
  import hsp_pkg::*;
;
  logic           ref_clk_in = 1'b0;
  logic           reset_n_in = 1'b0;
  logic           uv = 1'b0, ov = 1'b0, sense = 1'b0, retry = 1'b0;
  logic           vref = 1'b1, lim = 1'b0, scale = 1'b1;
  logic [1:0]     a0 = 2'd2, a1 = 2'd1, a2 = 2'd0;
  logic [15:0]    temp = 16'd20;
  logic [6:0]     dev = 7'h15;
  logic           scl, pull, sda_oe, gate, pulse, al_oe;
  wire            sda;
  breaker_level_t brk;
  logic [6:0]     addr;
  int             n_mismatch = 0;
  int             compares = 0;

  // Open-drain data wire with pull-up
  assign sda = ~(pull | sda_oe);

  // System clock, 25 MHz
  always #20 ref_clk_in = ~ref_clk_in;

  hot_swap_protect_control #(.SAMPLE_CYCLES(3000))
    hot_swap_protect_control_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .link_clk_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
    .undervolt_enable_pin_in(uv), .overvolt_lockout_pin_in(ov),
    .sense_over_4mv_in(sense), .vref_above_2v55_in(vref),
    .supply_above_4v1_in(1'b1), .addr_select_pin_0_in(a0),
    .addr_select_pin_1_in(a1), .addr_select_pin_2_in(a2),
    .limit_select_setting_in(lim), .breaker_scale_setting_in(scale),
    .temp_code_in(temp), .retry_exhausted_in(retry),
    .gate_on_out(gate), .diode_pulse_out(pulse),
    .alert_out_pin_out(), .alert_out_pin_oe_out(al_oe),
    .breaker_level_out(brk), .bus_addr_out(addr));

  smbus_host smbus_host_i (.scl_out(scl), .pull_out(pull), .sda_in(sda));

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    input int n);
    smbus_host_i.write(dev, c, d, n);
    cyc(1);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] c,
                        input logic [15:0] e);
    logic [15:0] v;
    smbus_host_i.read(dev, c, v);
    cyc(1);
    `CHK(nm, e, v)
  endtask

  // Waits out one diode pulse, measures it, lets flags settle
  task automatic sample();
    int k;
    int hi;
    hi = 0;
    // Skip a pulse already under way so the whole pulse is timed
    for (k = 0; k < 3000 && pulse !== 1'b0; k++) cyc(1);
    for (k = 0; k < 1000 && pulse !== 1'b1; k++) cyc(1);
    while (pulse === 1'b1 && hi < 3000) begin
      hi++;
      cyc(1);
    end
    cyc(3);
    `CHK("pulse_len", 2500, hi)
  endtask

  task automatic summarize();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    #3000000;
    n_mismatch++;
    summarize();
  end

  // Test sequence
  initial begin
    cyc(8);
    reset_n_in = 1'b1;
    uv = 1'b1;
    cyc(12);
    `CHK("addr", 7'h15, addr)
    `CHK("brk", BRK_193MV, brk)
    rd_chk("out_ctrl", 8'h03, 16'h0080);
    rd_chk("fault_thr", 8'h4f, 16'h0096);
    rd_chk("warn_thr", 8'h51, 16'h007d);
    rd_chk("suppress", 8'hd8, 16'h0000);
    `CHK("gate", 1'b1, gate)
    temp = 16'd100;
    sample();
    rd_chk("temp", 8'h8d, 16'd100);
    `CHK("alert", 1'b0, al_oe)
    temp = 16'd126;
    sample();
    `CHK("alert", 1'b1, al_oe)
    `CHK("gate", 1'b1, gate)
    temp = 16'd151;
    sample();
    `CHK("gate", 1'b0, gate)
    rd_chk("summary", 8'he1, 16'h0018);
    temp = 16'd20;
    sample();
    `CHK("gate", 1'b0, gate)
    wr(8'h03, 16'h0000, 1);
    wr(8'h03, 16'h0080, 1);
    `CHK("gate", 1'b1, gate)
    `CHK("alert", 1'b0, al_oe)
    wr(8'h51, 16'd50, 2);
    wr(8'h4f, 16'd55, 2);
    rd_chk("warn_thr", 8'h51, 16'd50);
    temp = 16'd52;
    sample();
    `CHK("alert", 1'b1, al_oe)
    `CHK("gate", 1'b1, gate)
    temp = 16'd56;
    sample();
    `CHK("gate", 1'b0, gate)
    temp = 16'd20;
    sample();
    wr(8'h03, 16'h0000, 1);
    wr(8'h03, 16'h0080, 1);
    sense = 1'b1;
    cyc(8);
    rd_chk("vendor", 8'h80, 16'h0000);
    wr(8'h03, 16'h0000, 1);
    `CHK("gate", 1'b0, gate)
    cyc(8);
    rd_chk("vendor", 8'h80, 16'h0001);
    rd_chk("summary", 8'he1, 16'h0020);
    `CHK("alert", 1'b1, al_oe)
    wr(8'hd8, 16'h0020, 2);
    cyc(4);
    `CHK("alert", 1'b0, al_oe)
    sense = 1'b0;
    wr(8'h03, 16'h0000, 1);
    wr(8'h03, 16'h0080, 1);
    rd_chk("vendor", 8'h80, 16'h0000);
    a0 = 2'd0;
    a2 = 2'd1;
    lim = 1'b1;
    scale = 1'b0;
    ov = 1'b1;
    cyc(8);
    `CHK("gate", 1'b0, gate)
    ov = 1'b0;
    cyc(8);
    `CHK("gate", 1'b1, gate)
    uv = 1'b0;
    cyc(8);
    `CHK("gate", 1'b0, gate)
    uv = 1'b1;
    cyc(8);
    retry = 1'b1;
    cyc(1);
    retry = 1'b0;
    cyc(8);
    `CHK("gate", 1'b0, gate)
    rd_chk("summary", 8'he1, 16'h0004);
    uv = 1'b0;
    cyc(8);
    uv = 1'b1;
    cyc(8);
    `CHK("gate", 1'b1, gate)
    `CHK("addr", 7'h15, addr)
    rd_chk("warn_thr", 8'h51, 16'd50);
    dev = 7'h16;
    wr(8'h51, 16'h1234, 2);
    dev = 7'h15;
    rd_chk("warn_thr", 8'h51, 16'd50);
    vref = 1'b0;
    cyc(10);
    `CHK("gate", 1'b0, gate)
    vref = 1'b1;
    cyc(12);
    `CHK("addr", 7'h1c, addr)
    `CHK("brk", BRK_48MV, brk)
    dev = 7'h1c;
    rd_chk("warn_thr", 8'h51, 16'h007d);
    rd_chk("suppress", 8'hd8, 16'h0000);
    `CHK("nack", 4, smbus_host_i.nack_cnt)
    summarize();
  end
endmodule
